// >>> verilog/rx_pcs_lane_align_status.sv
// receive PCS lane alignment and error status with AXI4-Lite register access
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - each lane's repeat fault rises after four marker errors in a row and stays until a good marker arrives.
// - each lane's marker word fault pulses one cycle per malformed marker, back to back allowed.
// - misalignment is never flagged until markers were once good on all lanes and then a bad one came.
// - misalignment is a one-cycle pulse one metaframe after the offending marker error.
// - the alignment error level is high on an alignment error or after alignment was lost.
// - each lane has its own one-cycle pulse for a failed BIP8 check.
// - the all-aligned level is high only while every lane is aligned and deskewed.
// - the high error rate flag follows the measured high BER condition.
// - PCS status is high exactly when aligned and no high BER.
// - a 2-bit increment counts valid decoder words seen with the receive decoder in its error state.
// - a qualifier marks when the code-violation increment is valid.
// - an 8-bit mismatch increment carries each valid word's mismatch count, only while test pattern mode is on.
// - a qualifier marks when the mismatch increment is valid.
module rx_pcs_lane_align_status
	import rx_lane_status_pkg::*;
(
	input  wire  logic              clk,                     // core clock
	input  wire  logic              rst_n,                   // async reset, active low
	input  wire  logic [LANES-1:0]  lane_marker_seen,        // marker slot seen per lane
	input  wire  logic [LANES-1:0]  lane_marker_bad,         // marker in slot malformed
	input  wire  logic [LANES-1:0]  lane_bip_bad,            // BIP8 compare failed
	input  wire  logic [LANES-1:0]  lane_deskewed,           // lane deskew done
	input  wire  logic              ber_high_in,             // BER monitor over threshold
	input  wire  logic              decode_err_state,        // decoder in error state
	input  wire  logic              decode_word_valid,       // decoder word this cycle
	input  wire  logic [7:0]        pattern_mismatch_cnt,    // mismatches in this cycle
	input  wire  logic              pattern_word_valid,      // pattern checker word valid
	output logic [LANES-1:0]        lane_marker_repeat_fault,// repeated marker fault level
	output logic [LANES-1:0]        lane_marker_word_fault,  // marker word fault pulse
	output logic                    misaligned_pulse,        // misalignment pulse
	output logic                    align_error,             // alignment error level
	output logic [LANES-1:0]        lane_bip_fault,          // BIP8 fault pulses
	output logic                    lanes_aligned,           // all lanes aligned level
	output logic                    high_error_rate_flag,    // high BER level
	output logic                    pcs_status_ok,           // PCS status level
	output logic [1:0]              bad_code_incr,           // code violation increment
	output logic                    bad_code_incr_valid,     // qualifier for increment
	output logic [7:0]              pattern_err_incr,        // mismatch increment
	output logic                    pattern_err_incr_valid,  // qualifier for mismatch
	output logic                    irq,                     // interrupt level
	input  wire  logic [31:0]       s_axi_awaddr,            // write address
	input  wire  logic              s_axi_awvalid,           // write address valid
	output logic                    s_axi_awready,           // write address ready
	input  wire  logic [31:0]       s_axi_wdata,             // write data
	input  wire  logic [3:0]        s_axi_wstrb,             // write strobes
	input  wire  logic              s_axi_wvalid,            // write data valid
	output logic                    s_axi_wready,            // write data ready
	output logic [1:0]              s_axi_bresp,             // write response
	output logic                    s_axi_bvalid,            // write response valid
	input  wire  logic              s_axi_bready,            // write response ready
	input  wire  logic [31:0]       s_axi_araddr,            // read address
	input  wire  logic              s_axi_arvalid,           // read address valid
	output logic                    s_axi_arready,           // read address ready
	output logic [31:0]             s_axi_rdata,             // read data
	output logic [1:0]              s_axi_rresp,             // read response
	output logic                    s_axi_rvalid,            // read data valid
	input  wire  logic              s_axi_rready             // read data ready
);
	logic [2:0]        repeat_cnt_ff [LANES];
	logic [LANES-1:0]  marker_fault_ff;
	logic [LANES-1:0]  repeat_fault_ff;
	logic [LANES-1:0]  bip_fault_ff;
	logic [LANES-1:0]  lane_good_once_ff;
	align_state_t      align_ff;
	logic              mis_pending_ff;
	logic [MF_CNT_W-1:0] mf_cnt_ff;
	logic              mis_pulse_ff;
	logic              aligned_ff;
	logic              align_err_ff;
	logic              hi_ber_ff;
	logic              status_ff;
	logic [1:0]        bad_code_ff;
	logic              bad_code_v_ff;
	logic [7:0]        pat_err_ff;
	logic              pat_v_ff;
	logic              test_pat_en_ff;
	logic [IRQ_W-1:0]  irq_stat_ff;
	logic [IRQ_W-1:0]  irq_en_ff;
	logic [IRQ_W-1:0]  irq_clr;
	logic [IRQ_W-1:0]  irq_evt;
	logic              aw_got_ff;
	logic              w_got_ff;
	logic [31:0]       awaddr_ff;
	logic [31:0]       wdata_ff;
	logic [3:0]        wstrb_ff;
	logic              bvalid_ff;
	logic [1:0]        bresp_ff;
	logic              rvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	logic              any_bad;
	logic              all_deskewed;
	logic              wr_fire;

	assign any_bad      = |(lane_marker_seen & lane_marker_bad);
	assign all_deskewed = &lane_deskewed;

	// per-lane marker tracking, lane i on bit i
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				repeat_cnt_ff[i]     <= 3'h0;
				marker_fault_ff[i]   <= 1'b0;
				repeat_fault_ff[i]   <= 1'b0;
				bip_fault_ff[i]      <= 1'b0;
				lane_good_once_ff[i] <= 1'b0;
			end else begin
				marker_fault_ff[i] <= lane_marker_seen[i] & lane_marker_bad[i];
				bip_fault_ff[i]    <= lane_marker_seen[i] & lane_bip_bad[i];
				if (lane_marker_seen[i]) begin
					if (lane_marker_bad[i]) begin
						if (repeat_cnt_ff[i] != REPEAT_MAX)
							repeat_cnt_ff[i] <= repeat_cnt_ff[i] + 3'h1;
						if (repeat_cnt_ff[i] == REPEAT_MAX - 3'h1)
							repeat_fault_ff[i] <= 1'b1;
					end else begin
						repeat_cnt_ff[i]     <= 3'h0;
						repeat_fault_ff[i]   <= 1'b0;
						lane_good_once_ff[i] <= 1'b1;
					end
				end
			end
		end
	end

	// alignment tracking; lost state holds until every lane is deskewed again and no seen marker is bad
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			align_ff <= ALIGN_IDLE;
		end else begin
			case (align_ff)
				ALIGN_IDLE:
					if (&lane_good_once_ff && all_deskewed)
						align_ff <= ALIGN_LOCKED;
				ALIGN_LOCKED:
					if (!all_deskewed)
						align_ff <= ALIGN_LOST;
				ALIGN_LOST:
					if (all_deskewed && !any_bad)
						align_ff <= ALIGN_LOCKED;
				default:
					align_ff <= ALIGN_IDLE;
			endcase
		end
	end

	// one metaframe delay; a fresh error while waiting restarts the wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mis_pending_ff <= 1'b0;
			mf_cnt_ff      <= '0;
			mis_pulse_ff   <= 1'b0;
		end else begin
			mis_pulse_ff <= 1'b0;
			if (any_bad && (&lane_good_once_ff)) begin
				mis_pending_ff <= 1'b1;
				mf_cnt_ff      <= '0;
			end else if (mis_pending_ff) begin
				if (mf_cnt_ff == METAFRAME_WORDS - 14'h1) begin
					mis_pending_ff <= 1'b0;
					mis_pulse_ff   <= 1'b1;
				end else begin
					mf_cnt_ff <= mf_cnt_ff + 14'h1;
				end
			end
		end
	end

	// level status outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aligned_ff   <= 1'b0;
			align_err_ff <= 1'b0;
			hi_ber_ff    <= 1'b0;
			status_ff    <= 1'b0;
		end else begin
			aligned_ff   <= (align_ff == ALIGN_LOCKED) && all_deskewed;
			align_err_ff <= (align_ff == ALIGN_LOST) || ((align_ff == ALIGN_LOCKED) && !all_deskewed);
			hi_ber_ff    <= ber_high_in;
			status_ff    <= (align_ff == ALIGN_LOCKED) && all_deskewed && !ber_high_in;
		end
	end

	// statistics increments
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bad_code_ff   <= 2'h0;
			bad_code_v_ff <= 1'b0;
			pat_err_ff    <= 8'h00;
			pat_v_ff      <= 1'b0;
		end else begin
			bad_code_ff   <= (decode_word_valid && decode_err_state) ? 2'h1 : 2'h0;
			bad_code_v_ff <= decode_word_valid;
			pat_err_ff    <= (test_pat_en_ff && pattern_word_valid) ? pattern_mismatch_cnt : 8'h00;
			pat_v_ff      <= test_pat_en_ff && pattern_word_valid;
		end
	end

	assign lane_marker_repeat_fault = repeat_fault_ff;
	assign lane_marker_word_fault   = marker_fault_ff;
	assign lane_bip_fault           = bip_fault_ff;
	assign misaligned_pulse         = mis_pulse_ff;
	assign align_error              = align_err_ff;
	assign lanes_aligned            = aligned_ff;
	assign high_error_rate_flag     = hi_ber_ff;
	assign pcs_status_ok            = status_ff;
	assign bad_code_incr            = bad_code_ff;
	assign bad_code_incr_valid      = bad_code_v_ff;
	assign pattern_err_incr         = pat_err_ff;
	assign pattern_err_incr_valid   = pat_v_ff;

	// interrupts: set wins over a clear in the same cycle
	assign irq_evt[IRQ_MISALIGN]   = mis_pulse_ff;
	assign irq_evt[IRQ_ALIGN_LOSS] = align_err_ff;
	assign irq_evt[IRQ_HI_BER]     = hi_ber_ff;
	assign irq_evt[IRQ_PATTERN]    = |pat_err_ff;
	assign wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
	assign irq_clr = (wr_fire && awaddr_ff == ADDR_IRQ_CLEAR && wstrb_ff[0]) ? wdata_ff[IRQ_W-1:0] : '0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_stat_ff <= '0;
		else
			irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
	end
	assign irq = |(irq_stat_ff & irq_en_ff);

	// write channel: address and data taken in either order
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_ff <= 1'b0;
			w_got_ff  <= 1'b0;
			awaddr_ff <= 32'h0000_0000;
			wdata_ff  <= 32'h0000_0000;
			wstrb_ff  <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_got_ff <= 1'b0;
				w_got_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= (awaddr_ff == ADDR_IRQ_ENABLE || awaddr_ff == ADDR_IRQ_CLEAR ||
				              awaddr_ff == ADDR_CONTROL) ? RESP_OKAY : RESP_DECERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = !w_got_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// writable registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_en_ff      <= '0;
			test_pat_en_ff <= 1'b0;
		end else if (wr_fire && wstrb_ff[0]) begin
			if (awaddr_ff == ADDR_IRQ_ENABLE)
				irq_en_ff <= wdata_ff[IRQ_W-1:0];
			if (awaddr_ff == ADDR_CONTROL)
				test_pat_en_ff <= wdata_ff[CTL_TEST_PAT];
		end
	end

	// read channel, one cycle after the address is taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rresp_ff  <= RESP_OKAY;
			case (s_axi_araddr)
				ADDR_IRQ_STATUS: rdata_ff <= {28'h0000000, irq_stat_ff};
				ADDR_IRQ_ENABLE: rdata_ff <= {28'h0000000, irq_en_ff};
				ADDR_IRQ_CLEAR:  rdata_ff <= 32'h0000_0000;
				ADDR_CONTROL:    rdata_ff <= {31'h00000000, test_pat_en_ff};
				ADDR_LIVE:       rdata_ff <= {20'h00000, repeat_fault_ff, 1'b0, align_err_ff,
				                              status_ff, hi_ber_ff, aligned_ff, 3'h0};
				default: begin
					rdata_ff <= 32'h0000_0000;
					rresp_ff <= RESP_DECERR;
				end
			endcase
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	chk_repeat_after_four: assert property (@(posedge clk) disable iff (!rst_n)
		(lane_marker_seen[0] && lane_marker_bad[0]) [*1] ##0 (repeat_cnt_ff[0] == 3'h3)
		|=> lane_marker_repeat_fault[0]) else $error("repeat fault not raised on fourth error");
	chk_word_fault_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		(lane_marker_seen[1] && lane_marker_bad[1]) |=> lane_marker_word_fault[1])
		else $error("marker word fault missing");
	chk_misalign_needs_lock: assert property (@(posedge clk) disable iff (!rst_n)
		misaligned_pulse |-> (&lane_good_once_ff)) else $error("misalign before any good markers");
	chk_misalign_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
		(mis_pending_ff && mf_cnt_ff == METAFRAME_WORDS - 14'h1 && !(any_bad && (&lane_good_once_ff)))
		|=> misaligned_pulse ##1 !misaligned_pulse) else $error("misalign pulse timing wrong");
	chk_align_err_level: assert property (@(posedge clk) disable iff (!rst_n)
		(align_ff == ALIGN_LOST) |=> align_error) else $error("alignment error not raised");
	chk_bip_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(lane_bip_fault[2]) |-> $past(lane_marker_seen[2] && lane_bip_bad[2]))
		else $error("bip fault without cause");
	chk_aligned_needs_lanes: assert property (@(posedge clk) disable iff (!rst_n)
		lanes_aligned |-> $past(all_deskewed)) else $error("aligned while lane not deskewed");
	chk_status_relation: assert property (@(posedge clk) disable iff (!rst_n)
		pcs_status_ok == (lanes_aligned && !high_error_rate_flag)) else $error("status mismatch");
	chk_pattern_gated: assert property (@(posedge clk) disable iff (!rst_n)
		(pattern_err_incr != 8'h00) |-> $past(test_pat_en_ff) && pattern_err_incr_valid)
		else $error("mismatch increment while test mode off");
	chk_bad_code_qual: assert property (@(posedge clk) disable iff (!rst_n)
		(bad_code_incr != 2'h0) |-> bad_code_incr_valid) else $error("increment without qualifier");
endmodule

// >>> include/rx_lane_status_pkg.sv
// constants for the receive lane alignment status block
package rx_lane_status_pkg;
	localparam int          LANES           = 4;
	localparam int          REPEAT_LIMIT    = 4;
	localparam logic [2:0]  REPEAT_MAX      = 3'h4;
	localparam int          MF_CNT_W        = 14;
	localparam logic [13:0] METAFRAME_WORDS = 14'h3FFF;
	localparam logic [31:0] ADDR_IRQ_STATUS = 32'h0000_0000;
	localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h0000_0004;
	localparam logic [31:0] ADDR_IRQ_CLEAR  = 32'h0000_0008;
	localparam logic [31:0] ADDR_CONTROL    = 32'h0000_000C;
	localparam logic [31:0] ADDR_LIVE       = 32'h0000_0010;
	localparam int          IRQ_W           = 4;
	localparam int          IRQ_MISALIGN    = 0;
	localparam int          IRQ_ALIGN_LOSS  = 1;
	localparam int          IRQ_HI_BER      = 2;
	localparam int          IRQ_PATTERN     = 3;
	localparam int          CTL_TEST_PAT    = 0;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_DECERR     = 2'h3;
	typedef enum logic [1:0] {ALIGN_IDLE, ALIGN_LOCKED, ALIGN_LOST} align_state_t;
endpackage

// >>> dv/stat_counter_model.sv
// statistics counter model that consumes the qualified status increments
`timescale 1ns/1ps
module stat_counter_model (
	input  wire  logic        clk,                    // core clock
	input  wire  logic        rst_n,                  // async reset, active low
	input  wire  logic [1:0]  bad_code_incr,          // code violation increment
	input  wire  logic        bad_code_incr_valid,    // qualifier for code increment
	input  wire  logic [7:0]  pattern_err_incr,       // mismatch increment
	input  wire  logic        pattern_err_incr_valid, // qualifier for mismatch increment
	output logic [31:0]       code_total,             // accumulated code violations
	output logic [31:0]       pattern_total           // accumulated mismatches
);
	// increments outside their qualifier are junk, so they never reach the totals
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			code_total <= 32'h0;
		end else if (bad_code_incr_valid) begin
			code_total <= code_total + 32'(bad_code_incr);
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pattern_total <= 32'h0;
		end else if (pattern_err_incr_valid) begin
			pattern_total <= pattern_total + 32'(pattern_err_incr);
		end
	end
endmodule

// >>> dv/rx_pcs_lane_align_status_test.sv
// self-checking bench for the receive lane alignment status block
`timescale 1ns/1ps
module rx_pcs_lane_align_status_test;
	import rx_lane_status_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, ber = 1'b0, derr = 1'b0, dval = 1'b0, pval = 1'b0;
	logic [3:0]  seen = 4'h0, bad = 4'h0, bip = 4'h0, desk = 4'h0, s_axi_wstrb = 4'hF;
	logic [7:0]  pcnt = 8'h0;
	logic [3:0]  lane_marker_repeat_fault, lane_marker_word_fault, lane_bip_fault;
	logic        misaligned_pulse, align_error, lanes_aligned, high_error_rate_flag, pcs_status_ok, irq;
	logic [1:0]  bad_code_incr, s_axi_bresp, s_axi_rresp, rsp;
	logic [7:0]  pattern_err_incr;
	logic        bad_code_incr_valid, pattern_err_incr_valid, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic        s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd;
	logic [31:0] code_total, pattern_total, exp_code, exp_pat;
	logic [3:0]  exp_w, exp_b, exp_r;
	logic [2:0]  rep [4];
	logic        exp_h, exp_v, exp_d, hb_seen, ctl = 1'b0, quiet = 1'b1;
	int          num_errors = 0, compares = 0, n, rnd;

	rx_pcs_lane_align_status dut_u (.clk, .rst_n, .lane_marker_seen(seen), .lane_marker_bad(bad),
		.lane_bip_bad(bip), .lane_deskewed(desk), .ber_high_in(ber), .decode_err_state(derr),
		.decode_word_valid(dval), .pattern_mismatch_cnt(pcnt), .pattern_word_valid(pval),
		.lane_marker_repeat_fault, .lane_marker_word_fault, .misaligned_pulse, .align_error, .lane_bip_fault,
		.lanes_aligned, .high_error_rate_flag, .pcs_status_ok, .bad_code_incr, .bad_code_incr_valid,
		.pattern_err_incr, .pattern_err_incr_valid, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	stat_counter_model stats_u (.clk, .rst_n, .bad_code_incr, .bad_code_incr_valid, .pattern_err_incr,
		.pattern_err_incr_valid, .code_total, .pattern_total);

	always #5 clk = ~clk;

	// reference sees the pre-edge inputs, since the bench drives them by non-blocking assignment
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			{exp_w, exp_b, exp_r, exp_h, exp_v, exp_d, hb_seen} <= '0;
			{exp_code, exp_pat} <= '0;
			for (int i = 0; i < LANES; i++) rep[i] <= 3'h0;
		end else begin
			exp_w <= seen & bad;
			exp_b <= seen & bip;
			for (int i = 0; i < LANES; i++) begin
				if (seen[i]) begin
					rep[i] <= !bad[i] ? 3'h0 : (rep[i] == REPEAT_MAX) ? rep[i] : rep[i] + 3'h1;
					exp_r[i] <= bad[i] && (rep[i] >= REPEAT_MAX - 3'h1);
				end
			end
			exp_h <= ber;
			hb_seen <= hb_seen | ber;
			exp_v <= dval;
			exp_d <= dval & derr;
			exp_code <= exp_code + 32'(dval & derr);
			exp_pat <= exp_pat + ((pval & ctl) ? 32'(pcnt) : 32'h0);
		end
	end

	always @(negedge clk) begin
		if (rst_n) begin
			compare("word_fault", 32'(exp_w), 32'(lane_marker_word_fault));
			compare("bip_fault", 32'(exp_b), 32'(lane_bip_fault));
			compare("repeat_fault", 32'(exp_r), 32'(lane_marker_repeat_fault));
			compare("high_ber", 32'(exp_h), 32'(high_error_rate_flag));
			compare("pcs_status", 32'(lanes_aligned & ~high_error_rate_flag), 32'(pcs_status_ok));
			compare("code_incr", 32'(exp_d), 32'(bad_code_incr));
			compare("code_valid", 32'(exp_v), 32'(bad_code_incr_valid));
			if (quiet) compare("misaligned", 32'h0, 32'(misaligned_pulse));
		end
	end

	task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic print_verdict;
		if (num_errors == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
		logic aw_hit, w_hit, b_hit;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		b_hit = 1'b0;
		for (int k = 0; k < 1000 && !b_hit; k++) begin
			@(negedge clk);
			aw_hit = s_axi_awvalid & s_axi_awready;
			w_hit = s_axi_wvalid & s_axi_wready;
			b_hit = s_axi_bvalid & s_axi_bready;
			resp = s_axi_bresp;
			@(posedge clk);
			if (aw_hit) s_axi_awvalid <= 1'b0;
			if (w_hit) s_axi_wvalid <= 1'b0;
			if (b_hit) s_axi_bready <= 1'b0;
		end
	endtask

	task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic ar_hit, r_hit;
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		r_hit = 1'b0;
		for (int k = 0; k < 1000 && !r_hit; k++) begin
			@(negedge clk);
			ar_hit = s_axi_arvalid & s_axi_arready;
			r_hit = s_axi_rvalid & s_axi_rready;
			d = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ar_hit) s_axi_arvalid <= 1'b0;
			if (r_hit) s_axi_rready <= 1'b0;
		end
	endtask

	// before lock every presented marker is malformed, so lock can never form
	task automatic rand_cycle(input logic locked);
		@(posedge clk);
		seen <= 4'($urandom);
		bad <= locked ? 4'($urandom | $urandom) : 4'hF;
		bip <= 4'($urandom);
		ber <= ($urandom % 16 == 0) ? ~ber : ber;
		{derr, dval, pval} <= 3'($urandom);
		pcnt <= 8'($urandom);
	endtask

	task automatic quiet_inputs;
		@(posedge clk);
		{seen, bad, bip} <= '0;
		{ber, dval, pval} <= '0;
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		print_verdict();
	end

	initial begin
		rnd = $urandom(13083);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		desk <= 4'hF;
		@(negedge clk);
		compare("reset_levels", 32'h0, 32'({misaligned_pulse, align_error, lanes_aligned, irq}));
		repeat (300) rand_cycle(1'b0);
		quiet_inputs();
		repeat (16400) @(posedge clk);
		@(negedge clk);
		compare("aligned_prelock", 32'h0, 32'(lanes_aligned));
		// one good marker on every lane, held for a single cycle
		@(posedge clk);
		seen <= 4'hF;
		quiet_inputs();
		repeat (4) @(posedge clk);
		@(negedge clk);
		compare("aligned_lock", 32'h1, 32'({align_error, lanes_aligned}));
		quiet = 1'b0;
		@(posedge clk);
		{seen, bad} <= 8'h44;
		@(posedge clk);
		{seen, bad} <= 8'h00;
		n = 1;
		@(negedge clk);
		while (misaligned_pulse !== 1'b1 && n < 17000) begin
			@(negedge clk);
			n++;
		end
		compare("misalign_delay", 32'(METAFRAME_WORDS) + 32'h1, 32'(n));
		@(negedge clk);
		compare("misalign_width", 32'h0, 32'(misaligned_pulse));
		@(posedge clk);
		desk <= 4'hD;
		repeat (3) @(posedge clk);
		@(negedge clk);
		compare("align_loss", 32'h2, 32'({align_error, lanes_aligned}));
		@(posedge clk);
		desk <= 4'hF;
		repeat (3) @(posedge clk);
		@(negedge clk);
		compare("align_back", 32'h1, 32'({align_error, lanes_aligned}));
		axi_read(ADDR_IRQ_STATUS, rd, rsp);
		compare("irq_status", {29'h0, hb_seen, 2'h3}, rd);
		@(negedge clk);
		compare("irq_idle", 32'h0, 32'(irq));
		axi_read(ADDR_LIVE, rd, rsp);
		compare("live_status", 32'h0000_0028, rd);
		axi_write(ADDR_IRQ_ENABLE, 32'h2, rsp);
		repeat (2) @(posedge clk);
		@(negedge clk);
		compare("irq_raised", 32'h1, 32'(irq));
		axi_write(ADDR_IRQ_CLEAR, 32'hF, rsp);
		repeat (2) @(posedge clk);
		@(negedge clk);
		compare("irq_cleared", 32'h0, 32'(irq));
		axi_read(ADDR_IRQ_STATUS, rd, rsp);
		compare("status_cleared", 32'h0, rd);
		axi_read(ADDR_IRQ_ENABLE, rd, rsp);
		compare("enable_back", 32'h2, rd);
		axi_read(32'h0000_0040, rd, rsp);
		compare("unmapped_read", {30'h0, RESP_DECERR}, {30'h0, rsp});
		axi_write(32'h0000_0040, 32'h1, rsp);
		compare("unmapped_write", {30'h0, RESP_DECERR}, {30'h0, rsp});
		for (int pass = 1; pass >= 0; pass--) begin
			axi_write(ADDR_CONTROL, 32'(pass), rsp);
			ctl = pass[0];
			repeat (1000) rand_cycle(1'b1);
			quiet_inputs();
		end
		axi_read(ADDR_CONTROL, rd, rsp);
		compare("control_back", 32'h0, rd);
		repeat (5) @(posedge clk);
		@(negedge clk);
		compare("code_total", exp_code, code_total);
		compare("pattern_total", exp_pat, pattern_total);
		print_verdict();
	end
endmodule
